// >>> verilog/trlc_pkg.sv
// Constants and types shared by the temperature result and limit compare block.
package trlc_pkg;

    // ************************************************************
    // Channel numbering and widths
    // ************************************************************
    localparam int TRLC_NCH = 10;
    localparam logic [3:0] TRLC_CH_VDD = 4'h0;
    localparam logic [3:0] TRLC_CH_INT = 4'h1;
    localparam logic [3:0] TRLC_CH_EXT = 4'h2;
    localparam int TRLC_RES_W = 10;
    localparam int TRLC_LIM_W = 8;
    localparam int TRLC_AVG_N = 16;
    localparam int TRLC_ACC_W = 14;
    localparam logic [3:0] TRLC_AVG_LAST = 4'hf;

    // ************************************************************
    // Register byte addresses
    // ************************************************************
    localparam logic [7:0] TRLC_A_STAT1 = 8'h00;
    localparam logic [7:0] TRLC_A_STAT2 = 8'h01;
    localparam logic [7:0] TRLC_A_MSB0 = 8'h06;
    localparam logic [7:0] TRLC_A_CFG1 = 8'h18;
    localparam logic [7:0] TRLC_A_CFG2 = 8'h19;
    localparam logic [7:0] TRLC_A_MASK1 = 8'h1c;
    localparam logic [7:0] TRLC_A_MASK2 = 8'h1d;
    localparam logic [7:0] TRLC_A_OFFS = 8'h1e;
    localparam logic [7:0] TRLC_A_LIM0 = 8'h20;

    // ************************************************************
    // Field positions and reset values
    // ************************************************************
    localparam int TRLC_CFG1_POL_BIT = 3;
    localparam int TRLC_CFG2_AVGDIS_BIT = 5;
    localparam logic [7:0] TRLC_CFG1_RST = 8'h08;
    localparam logic [7:0] TRLC_CFG2_RST = 8'h00;
    localparam logic [15:0] TRLC_MASK_RST = 16'hffff;
    localparam logic [7:0] TRLC_OFFS_RST = 8'h00;
    localparam logic [7:0] TRLC_LIM_HI_RST = 8'h7f;
    localparam logic [7:0] TRLC_LIM_LO_RST = 8'h80;
    localparam int TRLC_VDD_FLAG_POS = 9;

    // ************************************************************
    // Carriers
    // ************************************************************
    typedef struct packed {
        logic valid;
        logic [3:0] chan;
        logic [9:0] code;
    } trlc_conv_t;

    typedef struct packed {
        logic en;
        logic [7:0] addr;
        logic [7:0] data;
    } trlc_wr_t;

endpackage

// >>> verilog/trlc_core.sv
// Result averaging, limit comparison, status flags and interrupt pin.
`timescale 1ns/1ps

module trlc_core
    import trlc_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Converter results
    input trlc_conv_t conv_i,
    // Register access from the serial interface
    input trlc_wr_t wr_i,
    input wire logic rd_en,
    input wire logic [7:0] rd_addr,
    output logic [7:0] rd_data_q,
    // Interrupt pin
    output logic int_q
);

    // ************************************************************
    // Decoding helpers
    // ************************************************************
    function automatic logic [3:0] flag_pos(input logic [3:0] ch);
        flag_pos = (ch == TRLC_CH_VDD) ? 4'(TRLC_VDD_FLAG_POS) : 4'(ch - 4'h1);
    endfunction

    function automatic logic chan_signed(input logic [3:0] ch);
        chan_signed = (ch == TRLC_CH_INT) || (ch == TRLC_CH_EXT);
    endfunction

    // ************************************************************
    // Control registers
    // ************************************************************
    logic [7:0] cfg1_q;
    logic [7:0] cfg2_q;
    logic [15:0] mask_q;
    logic [7:0] offs_q;
    logic [TRLC_LIM_W-1:0] lim_hi_q [TRLC_NCH];
    logic [TRLC_LIM_W-1:0] lim_lo_q [TRLC_NCH];
    logic avg_dis;
    logic pol_high;
    logic [7:0] lim_idx;

    assign avg_dis = cfg2_q[TRLC_CFG2_AVGDIS_BIT];
    assign pol_high = cfg1_q[TRLC_CFG1_POL_BIT];
    assign lim_idx = wr_i.addr - TRLC_A_LIM0;

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            cfg1_q <= TRLC_CFG1_RST;
            cfg2_q <= TRLC_CFG2_RST;
            mask_q <= TRLC_MASK_RST;
            offs_q <= TRLC_OFFS_RST;
        end
        else if (wr_i.en)
        begin
            case (wr_i.addr)
                TRLC_A_CFG1: cfg1_q <= wr_i.data;
                TRLC_A_CFG2: cfg2_q <= wr_i.data;
                TRLC_A_MASK1: mask_q[7:0] <= wr_i.data;
                TRLC_A_MASK2: mask_q[15:8] <= wr_i.data;
                TRLC_A_OFFS: offs_q <= wr_i.data;
                default: ;
            endcase
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < TRLC_NCH; gi++)
        begin : g_lim
            always_ff @(posedge sys_clk)
            begin
                if (!rst_n)
                begin
                    lim_hi_q[gi] <= TRLC_LIM_HI_RST;
                    lim_lo_q[gi] <= TRLC_LIM_LO_RST;
                end
                else if (wr_i.en && lim_idx == 8'(2 * gi))
                    lim_hi_q[gi] <= wr_i.data;
                else if (wr_i.en && lim_idx == 8'(2 * gi + 1))
                    lim_lo_q[gi] <= wr_i.data;
            end
        end
    endgenerate

    // ************************************************************
    // Averaging and result store
    // ************************************************************
    logic [TRLC_ACC_W-1:0] acc_q [TRLC_NCH];
    logic [3:0] cnt_q [TRLC_NCH];
    logic [TRLC_RES_W-1:0] res_q [TRLC_NCH];
    logic store_q;
    logic [3:0] store_ch_q;
    logic [TRLC_RES_W-1:0] sample;
    logic [TRLC_ACC_W-1:0] acc_sum;
    logic conv_ok;

    assign sample = (conv_i.chan == TRLC_CH_INT) ?
        TRLC_RES_W'(conv_i.code + {{2{offs_q[7]}}, offs_q}) : conv_i.code;
    assign conv_ok = conv_i.valid && (conv_i.chan < 4'(TRLC_NCH));
    assign acc_sum = acc_q[conv_i.chan] + {{4{sample[9]}}, sample};

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
        begin
            store_q <= 1'b0;
            store_ch_q <= 4'h0;
            for (int i = 0; i < TRLC_NCH; i++)
            begin
                acc_q[i] <= '0;
                cnt_q[i] <= 4'h0;
                res_q[i] <= '0;
            end
        end
        else
        begin
            store_q <= 1'b0;
            if (conv_ok)
            begin
                store_ch_q <= conv_i.chan;
                if (avg_dis)
                begin
                    res_q[conv_i.chan] <= sample;
                    store_q <= 1'b1;
                end
                else if (cnt_q[conv_i.chan] == TRLC_AVG_LAST)
                begin
                    res_q[conv_i.chan] <= acc_sum[TRLC_ACC_W-1:4];
                    acc_q[conv_i.chan] <= '0;
                    cnt_q[conv_i.chan] <= 4'h0;
                    store_q <= 1'b1;
                end
                else
                begin
                    acc_q[conv_i.chan] <= acc_sum;
                    cnt_q[conv_i.chan] <= cnt_q[conv_i.chan] + 4'h1;
                end
            end
        end
    end

    // ************************************************************
    // Limit comparison and status flags
    // ************************************************************
    logic [TRLC_LIM_W-1:0] top8;
    logic [TRLC_LIM_W-1:0] hi_l;
    logic [TRLC_LIM_W-1:0] lo_l;
    logic over_hi;
    logic under_lo;
    logic [15:0] set_vec;
    logic [15:0] clr_vec;
    logic [15:0] flags_q;
    logic [3:0] pos;

    assign top8 = res_q[store_ch_q][TRLC_RES_W-1:2];
    assign hi_l = lim_hi_q[store_ch_q];
    assign lo_l = lim_lo_q[store_ch_q];
    assign pos = flag_pos(store_ch_q);

    always_comb
    begin
        if (chan_signed(store_ch_q))
        begin
            over_hi = $signed(top8) > $signed(hi_l);
            under_lo = $signed(top8) <= $signed(lo_l);
        end
        else
        begin
            over_hi = top8 > hi_l;
            under_lo = top8 <= lo_l;
        end
        set_vec = '0;
        if (store_q && (over_hi || under_lo) && !mask_q[pos])
            set_vec[pos] = 1'b1;
        clr_vec = '0;
        if (rd_en && rd_addr == TRLC_A_STAT1)
            clr_vec[7:0] = 8'hff;
        if (rd_en && rd_addr == TRLC_A_STAT2)
            clr_vec[15:8] = 8'hff;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            flags_q <= '0;
        else
            flags_q <= (flags_q & ~clr_vec) | set_vec;
    end

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            int_q <= 1'b0;
        else
            int_q <= (|flags_q) ~^ pol_high;
    end

    // ************************************************************
    // Read port
    // ************************************************************
    logic [7:0] msb_idx;

    assign msb_idx = rd_addr - TRLC_A_MSB0;

    always_ff @(posedge sys_clk)
    begin
        if (!rst_n)
            rd_data_q <= 8'h00;
        else if (rd_en)
        begin
            if (rd_addr == TRLC_A_STAT1)
                rd_data_q <= flags_q[7:0];
            else if (rd_addr == TRLC_A_STAT2)
                rd_data_q <= flags_q[15:8];
            else if (msb_idx < 8'(TRLC_NCH))
                rd_data_q <= res_q[msb_idx[3:0]][TRLC_RES_W-1:2];
            else if (rd_addr == TRLC_A_CFG1)
                rd_data_q <= cfg1_q;
            else if (rd_addr == TRLC_A_CFG2)
                rd_data_q <= cfg2_q;
            else
                rd_data_q <= 8'h00;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);

    avg_store_a: assert property (conv_ok && !avg_dis && cnt_q[conv_i.chan] == TRLC_AVG_LAST
        |=> store_q) else $error("average not stored after sixteen");
    avg_hold_a: assert property (conv_ok && !avg_dis && cnt_q[conv_i.chan] != TRLC_AVG_LAST
        |=> !store_q) else $error("result stored before sixteen");
    offset_add_a: assert property (conv_ok && avg_dis && conv_i.chan == TRLC_CH_INT
        |=> res_q[TRLC_CH_INT] == $past(TRLC_RES_W'(conv_i.code + {{2{offs_q[7]}}, offs_q})))
        else $error("internal offset not applied");
    flag_set_a: assert property (store_q && over_hi && !mask_q[pos]
        |=> flags_q[$past(pos)]) else $error("high violation not flagged");
    mask_block_a: assert property (store_q && mask_q[pos] && !flags_q[pos]
        |=> !flags_q[$past(pos)]) else $error("masked channel flagged");
    flag_sticky_a: assert property (flags_q[0] && !(rd_en && rd_addr == TRLC_A_STAT1)
        |=> flags_q[0]) else $error("flag dropped without read");
    read_clear_a: assert property (rd_en && rd_addr == TRLC_A_STAT1 && set_vec[7:0] == 8'h00
        |=> flags_q[7:0] == 8'h00 && rd_data_q == $past(flags_q[7:0]))
        else $error("status read did not clear");
    int_level_a: assert property (set_vec != 16'h0000 ##1 1'b1
        |=> int_q == pol_high || $changed(pol_high)) else $error("interrupt not active");

endmodule // trlc_core

// >>> dv/trlc_host.sv
// Host model that drives register accesses and converter samples.
`timescale 1ns/1ps
module trlc_host
    import trlc_pkg::*;
(
    // Clock
    input wire logic sys_clk,
    // Requests towards the block
    output trlc_conv_t conv_i,
    output trlc_wr_t wr_i,
    output logic rd_en,
    output logic [7:0] rd_addr,
    // Read answer
    input wire logic [7:0] rd_data_q
);
    initial
    begin
        conv_i = '0;
        wr_i = '0;
        rd_en = 1'b0;
        rd_addr = 8'h00;
    end

    // Released qualifiers show the inverse of their last value.
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        wr_i = '{1'b1, a, d};
        @(negedge sys_clk);
        wr_i = '{1'b0, ~a, ~d};
    endtask

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge sys_clk);
        rd_en = 1'b1;
        rd_addr = a;
        @(negedge sys_clk);
        rd_en = 1'b0;
        rd_addr = ~a;
        @(negedge sys_clk);
        d = rd_data_q;
    endtask

    task automatic conv(input logic [3:0] ch, input logic [9:0] c);
        @(negedge sys_clk);
        conv_i = '{1'b1, ch, c};
        @(negedge sys_clk);
        conv_i = '{1'b0, ~ch, ~c};
    endtask

    task automatic idle(input int n);
        repeat (n) @(negedge sys_clk);
    endtask

    task automatic mask(input logic [15:0] m);
        wr(TRLC_A_MASK1, m[7:0]);
        wr(TRLC_A_MASK2, m[15:8]);
    endtask
endmodule // trlc_host

// >>> dv/temp_result_limit_compare_tb_top.sv
// Self-checking bench for result averaging, limit compare and the interrupt pin.
`timescale 1ns/1ps
module temp_result_limit_compare_tb_top
    import trlc_pkg::*;
();
    logic sys_clk = 1'b0;
    logic rst_n;
    // Nets driven by the host model and by the block.
    wire trlc_conv_t conv_i;
    wire trlc_wr_t wr_i;
    wire logic rd_en;
    wire logic [7:0] rd_addr;
    wire logic [7:0] rd_data_q;
    wire logic int_q;
    int n_errors = 0;
    int checks = 0;
    int cycles = 0;

    always #5 sys_clk = ~sys_clk;

    trlc_core dut (.sys_clk(sys_clk), .rst_n(rst_n), .conv_i(conv_i), .wr_i(wr_i),
        .rd_en(rd_en), .rd_addr(rd_addr), .rd_data_q(rd_data_q), .int_q(int_q));
    trlc_host u_host (.sys_clk(sys_clk), .conv_i(conv_i), .wr_i(wr_i), .rd_en(rd_en),
        .rd_addr(rd_addr), .rd_data_q(rd_data_q));

    // ************************************************************
    // Checking helpers
    // ************************************************************
    task automatic complete_run();
        $display("Checks %0d errors %0d", checks, n_errors);
        if (n_errors == 0 && checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_errors++;
            $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        u_host.rd(a, d);
        chk(d, exp);
    endtask

    function automatic logic hit(input logic [3:0] ch, input logic [9:0] c,
        input logic [7:0] hi, input logic [7:0] lo);
        if (ch == TRLC_CH_INT || ch == TRLC_CH_EXT)
            return $signed(c[9:2]) > $signed(hi) || $signed(c[9:2]) <= $signed(lo);
        return c[9:2] > hi || c[9:2] <= lo;
    endfunction

    function automatic logic [7:0] stat_addr(input logic [3:0] ch);
        return (ch == TRLC_CH_VDD || ch == 4'h9) ? TRLC_A_STAT2 : TRLC_A_STAT1;
    endfunction

    function automatic logic [7:0] stat_bit(input logic [3:0] ch);
        if (ch == TRLC_CH_VDD)
            return 8'h02;
        if (ch == 4'h9)
            return 8'h01;
        return 8'h01 << (ch - 4'h1);
    endfunction

    function automatic logic [7:0] avg_msb(input int s);
        logic [9:0] r;
        r = 10'(s >>> 4);
        return r[9:2];
    endfunction

    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            n_errors++;
            complete_run();
        end
    end

    // ************************************************************
    // Main sequence
    // ************************************************************
    initial
    begin
        logic [3:0] ch;
        logic [9:0] c;
        logic [9:0] ce;
        logic [7:0] hi;
        logic [7:0] lo;
        logic [7:0] off;
        int sum;
        rst_n = 1'b0;
        void'($urandom(62981));
        repeat (20) @(negedge sys_clk);
        rst_n = 1'b1;
        chk({7'h0, int_q}, 8'h00);
        rd_chk(TRLC_A_CFG1, TRLC_CFG1_RST);
        rd_chk(TRLC_A_CFG2, TRLC_CFG2_RST);
        rd_chk(TRLC_A_STAT1, 8'h00);
        rd_chk(8'h02, 8'h00);
        u_host.wr(TRLC_A_CFG2, 8'h20);
        u_host.mask(16'h0000);
        off = 8'h00;
        for (int i = 0; i < 40; i++)
        begin
            ch = 4'($urandom % 10);
            c = 10'($urandom);
            hi = 8'($urandom);
            lo = 8'($urandom);
            if (i < 3)
            begin
                ch = TRLC_CH_EXT;
                c = 10'h064;
                hi = (i == 0) ? 8'h19 : (i == 1) ? 8'h18 : 8'h7f;
                lo = (i == 2) ? 8'h19 : 8'h18;
            end
            if (i == 3)
            begin
                ch = TRLC_CH_INT;
                c = 10'h360;
                hi = 8'h00;
                lo = 8'h80;
            end
            if (i > 3 && ch == TRLC_CH_INT)
            begin
                off = 8'($urandom);
                u_host.wr(TRLC_A_OFFS, off);
            end
            ce = (ch == TRLC_CH_INT) ? c + {{2{off[7]}}, off} : c;
            u_host.wr(TRLC_A_LIM0 + 8'(2 * ch), hi);
            u_host.wr(TRLC_A_LIM0 + 8'(2 * ch) + 8'h01, lo);
            u_host.conv(ch, c);
            u_host.idle(3);
            chk({7'h0, int_q}, {7'h0, hit(ch, ce, hi, lo)});
            rd_chk(TRLC_A_MSB0 + 8'(ch), ce[9:2]);
            rd_chk(stat_addr(ch), hit(ch, ce, hi, lo) ? stat_bit(ch) : 8'h00);
            rd_chk(stat_addr(ch), 8'h00);
            chk({7'h0, int_q}, 8'h00);
        end
        rst_n = 1'b0;
        u_host.idle(2);
        rst_n = 1'b1;
        rd_chk(TRLC_A_CFG2, TRLC_CFG2_RST);
        chk({7'h0, int_q}, 8'h00);
        sum = 0;
        for (int k = 0; k < 16; k++)
        begin
            c = (k == 0) ? 10'h200 : 10'($urandom);
            sum += $signed(c);
            if (k == 15)
                rd_chk(TRLC_A_MSB0 + 8'h02, 8'h00);
            u_host.conv(TRLC_CH_EXT, c);
        end
        u_host.idle(2);
        rd_chk(TRLC_A_MSB0 + 8'h02, avg_msb(sum));
        u_host.wr(TRLC_A_CFG1, 8'h00);
        u_host.wr(TRLC_A_CFG2, 8'h20);
        u_host.wr(TRLC_A_LIM0 + 8'h06, 8'h00);
        u_host.conv(4'h3, 10'h3ff);
        u_host.idle(3);
        chk({7'h0, int_q}, 8'h01);
        rd_chk(TRLC_A_STAT1, 8'h00);
        u_host.mask(16'hfffb);
        u_host.conv(4'h3, 10'h3ff);
        u_host.idle(3);
        chk({7'h0, int_q}, 8'h00);
        rd_chk(TRLC_A_STAT1, 8'h04);
        // out-of-range channel and status writes are ignored
        u_host.mask(16'h0000);
        u_host.wr(TRLC_A_STAT1, 8'hff);
        u_host.wr(TRLC_A_STAT2, 8'hff);
        u_host.conv(4'hc, 10'h3ff);
        u_host.idle(3);
        chk({7'h0, int_q}, 8'h01);
        rd_chk(TRLC_A_STAT1, 8'h00);
        rd_chk(TRLC_A_STAT2, 8'h00);
        rd_chk(TRLC_A_MSB0 + 8'h03, 8'hff);
        complete_run();
    end
endmodule // temp_result_limit_compare_tb_top
